/* common/move_pkg.sv */
// Shared constants for the data-move execution unit and its register file.
package move_pkg;

  // Operand sizes; long is used only for whole-register address updates.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // Addressing-mode codes presented on the instruction port.
  localparam logic [3:0] MODE_IMM     = 4'h0;
  localparam logic [3:0] MODE_REG     = 4'h1;
  localparam logic [3:0] MODE_IND     = 4'h2;
  localparam logic [3:0] MODE_DISP16  = 4'h3;
  localparam logic [3:0] MODE_DISP24  = 4'h4;
  localparam logic [3:0] MODE_POSTINC = 4'h5;
  localparam logic [3:0] MODE_PREDEC  = 4'h6;
  localparam logic [3:0] MODE_ABS8    = 4'h7;
  localparam logic [3:0] MODE_ABS16   = 4'h8;
  localparam logic [3:0] MODE_ABS24   = 4'h9;

  // Execution length in clock states per form.
  localparam logic [4:0] STATES_2  = 5'h2;
  localparam logic [4:0] STATES_4  = 5'h4;
  localparam logic [4:0] STATES_6  = 5'h6;
  localparam logic [4:0] STATES_8  = 5'h8;
  localparam logic [4:0] STATES_10 = 5'ha;

  // Address register step for the auto-increment and auto-decrement forms.
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;

  // Condition flag bit positions inside the flag register.
  localparam int unsigned FLAG_I = 7;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_V = 1;
  localparam int unsigned FLAG_C = 0;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;

  // Wishbone register byte offsets.
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_FLAGS    = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_COUNT    = 8'h0c;
  localparam logic [7:0] ADDR_GPR_BASE = 8'h20;
  localparam logic       CTRL_RESET    = 1'b1;

  // Number of clock states a move form takes; unknown codes act as short no-ops.
  function automatic logic [4:0] state_count(input logic [1:0] size, input logic [3:0] mode);
    logic [4:0] n;
    n = STATES_2;
    case (mode)
      MODE_IMM:     n = (size == SIZE_WORD) ? STATES_4 : STATES_2;
      MODE_REG:     n = STATES_2;
      MODE_IND:     n = STATES_4;
      MODE_DISP16:  n = STATES_6;
      MODE_DISP24:  n = STATES_10;
      MODE_POSTINC: n = STATES_6;
      MODE_PREDEC:  n = STATES_6;
      MODE_ABS8:    n = STATES_4;
      MODE_ABS16:   n = STATES_6;
      MODE_ABS24:   n = STATES_8;
      default:      n = STATES_2;
    endcase
    return n;
  endfunction

endpackage

/* src/gpr_file.sv */
// Eight 32-bit general registers with byte, word and long views.
`timescale 1ns/10ps
module gpr_file
  import move_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // View read port: sel[2:0] register, sel[3] picks low byte or upper word.
  input  wire logic [3:0]  view_sel_i,
  input  wire logic [1:0]  view_size_i,
  output logic      [15:0] view_data_o,
  // Whole-register read ports.
  input  wire logic [2:0]  addr_sel_i,
  output logic      [31:0] addr_data_o,
  input  wire logic [2:0]  dbg_sel_i,
  output logic      [31:0] dbg_data_o,
  // Single write port.
  input  wire logic        we_i,
  input  wire logic [1:0]  wr_size_i,
  input  wire logic [3:0]  wr_sel_i,
  input  wire logic [31:0] wr_data_i
);

  logic [31:0] gpr_q [8];

  // Merge a view write into the register, keeping every other bit.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [1:0] size,
                                        input logic half, input logic [31:0] data);
    logic [31:0] r;
    r = old;
    if (size == SIZE_BYTE)
    begin
      if (half)
        r[7:0] = data[7:0];
      else
        r[15:8] = data[7:0];
    end
    else if (size == SIZE_WORD)
    begin
      if (half)
        r[31:16] = data[15:0];
      else
        r[15:0] = data[15:0];
    end
    else
      r = data;
    return r;
  endfunction

  // One register per entry; only the selected one takes the write.
  for (genvar g = 0; g < 8; g++)
  begin : g_reg
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        gpr_q[g] <= 32'h0000_0000;
      else if (we_i && (wr_sel_i[2:0] == 3'(g)))
        gpr_q[g] <= merge(gpr_q[g], wr_size_i, wr_sel_i[3], wr_data_i);
    end
  end

  // Views: RnH is bits 15:8, RnL bits 7:0, Rn bits 15:0, En bits 31:16.
  always_comb
  begin
    view_data_o = 16'h0000;
    if (view_size_i == SIZE_BYTE)
      view_data_o = {8'h00, view_sel_i[3] ? gpr_q[view_sel_i[2:0]][7:0]
                                          : gpr_q[view_sel_i[2:0]][15:8]};
    else
      view_data_o = view_sel_i[3] ? gpr_q[view_sel_i[2:0]][31:16]
                                  : gpr_q[view_sel_i[2:0]][15:0];
  end

  // Whole 32-bit views.
  assign addr_data_o = gpr_q[addr_sel_i];
  assign dbg_data_o  = gpr_q[dbg_sel_i];

endmodule

/* src/move_exec.sv */
// Execution unit for byte and word data-move instructions.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module move_exec
  import move_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Decoded instruction stream.
  input  wire logic        ins_valid_i,
  output logic             ins_ready_o,
  input  wire logic [1:0]  ins_size_i,
  input  wire logic [3:0]  ins_mode_i,
  input  wire logic        ins_store_i,
  input  wire logic [3:0]  ins_dst_i,
  input  wire logic [3:0]  ins_src_i,
  input  wire logic [2:0]  ins_areg_i,
  input  wire logic [31:0] ins_ext_i,
  output logic             done_o,
  output logic      [7:0]  flags_o,
  // Memory bus master.
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic             mem_byte_o,
  output logic      [31:0] mem_addr_o,
  output logic      [15:0] mem_wdata_o,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_ack_i,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  typedef enum logic [1:0] {S_IDLE, S_MEM, S_POST, S_HOLD} exec_state_e;

  exec_state_e state_q;
  logic [4:0]  cnt_q;
  logic [4:0]  states_q;
  logic [1:0]  size_q;
  logic [3:0]  mode_q;
  logic        store_q;
  logic [3:0]  dst_q;
  logic [2:0]  areg_q;
  logic [7:0]  flags_q;
  logic        enable_q;
  logic [31:0] count_q;
  logic        wb_ack_q;
  logic [31:0] wb_dat_q;

  logic        accept;
  logic        is_mem;
  logic [31:0] step;
  logic [31:0] step_q;
  logic [31:0] ea;
  logic [15:0] src_val;
  logic [15:0] view_data;
  logic [31:0] addr_data;
  logic [31:0] dbg_data;
  logic [2:0]  addr_sel;
  logic        rf_we;
  logic [1:0]  rf_size;
  logic [3:0]  rf_sel;
  logic [31:0] rf_data;
  logic        flag_upd;
  logic [15:0] flag_val;
  logic [1:0]  flag_size;
  logic        wb_req;

  // Registered enable blocks new instructions but never aborts one in flight.
  assign accept      = ins_valid_i && ins_ready_o;
  assign ins_ready_o = (state_q == S_IDLE) && enable_q;
  assign is_mem      = (ins_mode_i != MODE_IMM) && (ins_mode_i != MODE_REG)
                       && (ins_mode_i <= MODE_ABS24);
  assign step        = (ins_size_i == SIZE_BYTE) ? STEP_BYTE : STEP_WORD;
  assign step_q      = (size_q == SIZE_BYTE) ? STEP_BYTE : STEP_WORD;
  assign addr_sel    = (state_q == S_IDLE) ? ins_areg_i : areg_q;

  gpr_file u_gpr (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .view_sel_i  (ins_src_i),
    .view_size_i (ins_size_i),
    .view_data_o (view_data),
    .addr_sel_i  (addr_sel),
    .addr_data_o (addr_data),
    .dbg_sel_i   (wb_adr_i[4:2]),
    .dbg_data_o  (dbg_data),
    .we_i        (rf_we),
    .wr_size_i   (rf_size),
    .wr_sel_i    (rf_sel),
    .wr_data_i   (rf_data)
  );

  // Effective address from the whole 32-bit address register or the extension word.
  always_comb
  begin
    ea = addr_data;
    case (ins_mode_i)
      MODE_IND, MODE_POSTINC: ea = addr_data;
      MODE_PREDEC:            ea = addr_data - step;
      MODE_DISP16, MODE_DISP24: ea = addr_data + ins_ext_i;
      MODE_ABS8, MODE_ABS16, MODE_ABS24: ea = ins_ext_i;
      default:                ea = addr_data;
    endcase
  end

  // Value a register-sourced or immediate move carries, cut to its size.
  always_comb
  begin
    src_val = (ins_mode_i == MODE_IMM) ? ins_ext_i[15:0] : view_data;
    if (ins_size_i == SIZE_BYTE)
      src_val = {8'h00, src_val[7:0]};
  end

  // The single write port serves four moments that never coincide.
  always_comb
  begin
    rf_we   = 1'b0;
    rf_size = SIZE_LONG;
    rf_sel  = 4'h0;
    rf_data = 32'h0000_0000;
    if (accept && ((ins_mode_i == MODE_IMM) || (ins_mode_i == MODE_REG)))
    begin
      rf_we   = 1'b1;
      rf_size = ins_size_i;
      rf_sel  = ins_dst_i;
      rf_data = {16'h0000, src_val};
    end
    else if (accept && (ins_mode_i == MODE_PREDEC))
    begin
      rf_we   = 1'b1;
      rf_sel  = {1'b0, ins_areg_i};
      rf_data = ea;
    end
    else if ((state_q == S_MEM) && mem_ack_i && !store_q)
    begin
      rf_we   = 1'b1;
      rf_size = size_q;
      rf_sel  = dst_q;
      rf_data = {16'h0000, (size_q == SIZE_BYTE) ? {8'h00, mem_rdata_i[7:0]}
                                                 : mem_rdata_i};
    end
    else if (state_q == S_POST)
    begin
      rf_we   = 1'b1;
      rf_sel  = {1'b0, areg_q};
      rf_data = addr_data + step_q;
    end
  end

  // Flags follow the transferred value: at accept for register sources, at ack for loads.
  always_comb
  begin
    flag_upd  = 1'b0;
    flag_val  = src_val;
    flag_size = ins_size_i;
    if (accept && ((ins_mode_i <= MODE_ABS24) && (!is_mem || ins_store_i)))
      flag_upd = 1'b1;
    else if ((state_q == S_MEM) && mem_ack_i && !store_q)
    begin
      flag_upd  = 1'b1;
      flag_val  = mem_rdata_i;
      flag_size = size_q;
    end
  end

  // Sequencer: memory phase, optional address update, then pad to the state count.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= S_IDLE;
    else
    begin
      unique case (state_q)
        S_IDLE: if (accept) state_q <= is_mem ? S_MEM : S_HOLD;
        S_MEM:  if (mem_ack_i) state_q <= (mode_q == MODE_POSTINC) ? S_POST : S_HOLD;
        S_POST: state_q <= S_HOLD;
        S_HOLD: if (done_o) state_q <= S_IDLE;
      endcase
    end
  end

  // State counter; the accept cycle is state one, so the count starts there.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 5'h0;
    else if (accept)
      cnt_q <= 5'h1;
    else if ((state_q != S_IDLE) && (cnt_q != 5'h1f))
      cnt_q <= cnt_q + 5'h1;
  end

  // A slow memory stretches the move; a fast one never shortens it below its count.
  assign done_o = (state_q == S_HOLD) && (cnt_q >= (states_q - 5'h1));

  // Instruction fields held for the later phases.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      states_q <= STATES_2;
      size_q   <= SIZE_BYTE;
      mode_q   <= MODE_IMM;
      store_q  <= 1'b0;
      dst_q    <= 4'h0;
      areg_q   <= 3'h0;
    end
    else if (accept)
    begin
      states_q <= state_count(ins_size_i, ins_mode_i);
      size_q   <= ins_size_i;
      mode_q   <= ins_mode_i;
      store_q  <= ins_store_i;
      dst_q    <= ins_dst_i;
      areg_q   <= ins_areg_i;
    end
  end

  // Memory request, held until acknowledged; the store value is taken at accept.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_byte_o  <= 1'b0;
      mem_addr_o  <= 32'h0000_0000;
      mem_wdata_o <= 16'h0000;
    end
    else if (accept && is_mem)
    begin
      mem_req_o   <= 1'b1;
      mem_we_o    <= ins_store_i;
      mem_byte_o  <= (ins_size_i == SIZE_BYTE);
      mem_addr_o  <= ea;
      mem_wdata_o <= src_val;
    end
    else if (mem_ack_i)
      mem_req_o <= 1'b0;
  end

  // Hardware flag update beats a software write in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_q <= FLAGS_RESET;
    else if (flag_upd)
    begin
      flags_q[FLAG_N] <= (flag_size == SIZE_BYTE) ? flag_val[7] : flag_val[15];
      flags_q[FLAG_Z] <= (flag_size == SIZE_BYTE) ? (flag_val[7:0] == 8'h00)
                                                  : (flag_val == 16'h0000);
      flags_q[FLAG_V] <= 1'b0;
      // Carry, half-carry and mask bits are left alone here.
    end
    else if (wb_req && wb_we_i && (wb_adr_i == ADDR_FLAGS) && wb_sel_i[0])
      flags_q <= wb_dat_i[7:0];
  end

  assign flags_o = flags_q;

  // Completed move counter, readable for software progress checks.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_q <= 32'h0000_0000;
    else if (done_o)
      count_q <= count_q + 32'h0000_0001;
  end

  // Wishbone: one-cycle registered ack; a request is seen only while ack is low.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      enable_q <= CTRL_RESET;
    else if (wb_req && wb_we_i && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0])
      enable_q <= wb_dat_i[0];
  end

  // Read mux; unmapped offsets read zero and still acknowledge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        if (wb_adr_i == ADDR_CTRL)
          wb_dat_q <= {31'h0, enable_q};
        else if (wb_adr_i == ADDR_FLAGS)
          wb_dat_q <= {24'h0, flags_q};
        else if (wb_adr_i == ADDR_STATUS)
          wb_dat_q <= {31'h0, (state_q != S_IDLE)};
        else if (wb_adr_i == ADDR_COUNT)
          wb_dat_q <= count_q;
        else if ((wb_adr_i >= ADDR_GPR_BASE) && (wb_adr_i[1:0] == 2'h0)
                 && (wb_adr_i < (ADDR_GPR_BASE + 8'h20)))
          wb_dat_q <= dbg_data;
        else
          wb_dat_q <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

endmodule

/* test/move_exec_monitor.sv */
// Port-level assertions for the data-move execution unit.
`timescale 1ns/10ps
module move_exec_monitor
  import move_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Instruction port.
  input wire logic        ins_valid_i,
  input wire logic        ins_ready_o,
  input wire logic [3:0]  ins_mode_i,
  input wire logic        done_o,
  input wire logic [7:0]  flags_o,
  // Memory port.
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic        mem_byte_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic        mem_ack_i
);
  logic ld_ack;
  logic take;

  // Load completion and instruction acceptance, named once for all checks.
  assign ld_ack = mem_req_o && mem_ack_i && !mem_we_o;
  assign take   = ins_valid_i && ins_ready_o;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  load_v_clr_a: assert property (ld_ack |=> !flags_o[FLAG_V])
    else $error("overflow flag not cleared by a load");
  load_nz_a: assert property (ld_ack |=>
    flags_o[FLAG_N] == ($past(mem_byte_o) ? $past(mem_rdata_i[7]) : $past(mem_rdata_i[15])) &&
    flags_o[FLAG_Z] == ($past(mem_byte_o) ? ($past(mem_rdata_i[7:0]) == 8'h00)
                                          : ($past(mem_rdata_i) == 16'h0000)))
    else $error("load flags do not match loaded data");
  keep_chi_a: assert property (ld_ack |=>
    $stable({flags_o[FLAG_I], flags_o[FLAG_H], flags_o[FLAG_C]}))
    else $error("load changed carry, half-carry or mask flag");
  store_flags_a: assert property ($rose(mem_req_o) && mem_we_o |-> !flags_o[FLAG_V] &&
    flags_o[FLAG_N] == (mem_byte_o ? mem_wdata_o[7] : mem_wdata_o[15]) &&
    flags_o[FLAG_Z] == (mem_byte_o ? mem_wdata_o[7:0] == 8'h00 : mem_wdata_o == 16'h0000))
    else $error("store flags do not match stored data");
  byte_upper_a: assert property (mem_req_o && mem_we_o && mem_byte_o |->
    mem_wdata_o[15:8] == 8'h00)
    else $error("byte store drives upper data bits");
  req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
    $stable(mem_addr_o) && $stable(mem_wdata_o) && $stable(mem_we_o))
    else $error("memory request changed before ack");
  req_drop_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("second memory access after ack");
  reg_len_a: assert property (take && ins_mode_i == MODE_REG |=> done_o)
    else $error("register move not done in two states");
  postinc_len_a: assert property (take && ins_mode_i == MODE_POSTINC |=>
    !done_o [*4] ##[1:40] done_o)
    else $error("post-increment move length wrong");
  predec_len_a: assert property (take && ins_mode_i == MODE_PREDEC |=>
    !done_o [*4] ##[1:40] done_o)
    else $error("pre-decrement move length wrong");
endmodule

bind move_exec move_exec_monitor u_move_exec_monitor (
  .clk_i, .rst_i, .ins_valid_i, .ins_ready_o, .ins_mode_i, .done_o, .flags_o, .mem_req_o,
  .mem_we_o, .mem_byte_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i
);

/* test/mem_model.sv */
// Behavioural byte memory answering the unit's bus after a chosen wait.
`timescale 1ns/10ps
module mem_model (
  // Clock, reset and wait length.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wait_i,
  // Bus from the unit.
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        byte_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             ack_o
);
  logic [7:0]  mem [256];
  logic [3:0]  cnt_q;
  logic [15:0] last_q;
  logic [15:0] data_w;
  logic [7:0]  a;

  // Words fold the upper address in, so a unit dropping address bits reads wrong data.
  assign a       = addr_i[7:0];
  assign data_w  = byte_i ? {8'h00, mem[a]} : {mem[a], mem[a + 8'h01]} ^ addr_i[31:16];
  assign ack_o   = req_i && cnt_q == wait_i;
  assign rdata_o = ack_o ? data_w : ~last_q;

  // Wait counting and writes; plain always so the bench may preload the array.
  always @(posedge clk_i)
  begin
    cnt_q <= (req_i && !ack_o && !rst_i) ? cnt_q + 4'h1 : 4'h0;
    if (rst_i)
      last_q <= 16'h0000;
    else if (ack_o)
      last_q <= data_w;
    if (ack_o && we_i)
      mem[a] <= byte_i ? wdata_i[7:0] : wdata_i[15:8];
    if (ack_o && we_i && !byte_i)
      mem[a + 8'h01] <= wdata_i[7:0];
  end
endmodule

/* test/move_exec_tb.sv */
// Self-checking bench for the data-move execution unit.
`timescale 1ns/10ps
module move_exec_tb
  import move_pkg::*;
;
  typedef struct packed {
    logic [1:0]  sz;
    logic [3:0]  md;
    logic        st;
    logic [3:0]  d;
    logic [3:0]  s;
    logic [2:0]  a;
    logic [31:0] x;
    logic [3:0]  w;
    logic [4:0]  n;
    logic [2:0]  r;
    logic [31:0] rv;
    logic [7:0]  f;
  } step_s;

  // Stimulus and observed ports.
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ins_valid_i = 1'b0;
  logic        ins_store_i = 1'b0;
  logic [1:0]  ins_size_i = 2'h0;
  logic [3:0]  ins_mode_i = 4'h0;
  logic [3:0]  ins_dst_i = 4'h0;
  logic [3:0]  ins_src_i = 4'h0;
  logic [2:0]  ins_areg_i = 3'h0;
  logic [31:0] ins_ext_i = 32'h0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wait_q = 4'h0;
  logic        ins_ready_o, done_o, mem_req_o, mem_we_o, mem_byte_o, mem_ack_i, wb_ack_o;
  logic [7:0]  flags_o;
  logic [31:0] mem_addr_o, wb_dat_o, rd;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  int          err_total = 0;
  int          total_checks = 0;
  // Each row: size, mode, store, dst, src, areg, ext, wait, states, reg, value, flags.
  step_s tbl [18] = '{
    '{2'h0, 4'h0, 1'b0, 4'h8, 4'h0, 3'h0, 32'h80, 4'h0, 5'h2, 3'h0, 32'h80, 8'ha9},
    '{2'h0, 4'h0, 1'b0, 4'h0, 4'h0, 3'h0, 32'h5a, 4'h0, 5'h2, 3'h0, 32'h5a80, 8'ha1},
    '{2'h1, 4'h0, 1'b0, 4'h8, 4'h0, 3'h0, 32'h0, 4'h0, 5'h4, 3'h0, 32'h5a80, 8'ha5},
    '{2'h1, 4'h0, 1'b0, 4'h9, 4'h0, 3'h0, 32'hf00d, 4'h0, 5'h4, 3'h1, 32'hf00d0000, 8'ha9},
    '{2'h1, 4'h1, 1'b0, 4'h1, 4'h0, 3'h0, 32'h0, 4'h0, 5'h2, 3'h1, 32'hf00d5a80, 8'ha1},
    '{2'h0, 4'h1, 1'b0, 4'h2, 4'h9, 3'h0, 32'h0, 4'h0, 5'h2, 3'h2, 32'h8000, 8'ha9},
    '{2'h1, 4'h0, 1'b0, 4'h3, 4'h0, 3'h0, 32'h10, 4'h0, 5'h4, 3'h3, 32'h10, 8'ha1},
    '{2'h0, 4'h5, 1'b0, 4'hc, 4'h0, 3'h3, 32'h0, 4'h0, 5'h6, 3'h3, 32'h11, 8'ha5},
    '{2'h1, 4'h5, 1'b0, 4'hc, 4'h0, 3'h3, 32'h0, 4'h0, 5'h6, 3'h4, 32'h81230000, 8'ha9},
    '{2'h0, 4'h6, 1'b1, 4'h0, 4'h0, 3'h3, 32'h0, 4'h0, 5'h6, 3'h3, 32'h12, 8'ha1},
    '{2'h1, 4'h2, 1'b0, 4'h5, 4'h0, 3'h1, 32'h0, 4'h0, 5'h4, 3'h5, 32'he239, 8'ha9},
    '{2'h0, 4'h3, 1'b0, 4'he, 4'h0, 3'h3, 32'hfffffffe, 4'h0, 5'h6, 3'h6, 32'h0, 8'ha5},
    '{2'h1, 4'h9, 1'b1, 4'h0, 4'h1, 3'h0, 32'h40, 4'h0, 5'h8, 3'h1, 32'hf00d5a80, 8'ha1},
    '{2'h0, 4'hf, 1'b0, 4'h0, 4'h0, 3'h0, 32'h0, 4'h0, 5'h2, 3'h1, 32'hf00d5a80, 8'ha1},
    '{2'h0, 4'h5, 1'b0, 4'hf, 4'h0, 3'h3, 32'h0, 4'h3, 5'h0, 3'h3, 32'h13, 8'ha1},
    '{2'h0, 4'h7, 1'b0, 4'h7, 4'h0, 3'h0, 32'h41, 4'h0, 5'h4, 3'h7, 32'h805a, 8'ha9},
    '{2'h0, 4'h4, 1'b1, 4'h0, 4'h5, 3'h3, 32'h3d, 4'h0, 5'ha, 3'h3, 32'h13, 8'ha9},
    '{2'h1, 4'h8, 1'b0, 4'he, 4'h0, 3'h0, 32'h50, 4'h1, 5'h6, 3'h6, 32'he2000000, 8'ha9}
  };

  move_exec u_move_exec (
    .clk_i, .rst_i, .ins_valid_i, .ins_ready_o, .ins_size_i, .ins_mode_i, .ins_store_i,
    .ins_dst_i, .ins_src_i, .ins_areg_i, .ins_ext_i, .done_o, .flags_o, .mem_req_o,
    .mem_we_o, .mem_byte_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o
  );
  mem_model u_mem_model (
    .clk_i, .rst_i, .wait_i(wait_q), .req_i(mem_req_o), .we_i(mem_we_o), .byte_i(mem_byte_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i)
  );

  // Free-running 40 MHz clock.
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One classic Wishbone cycle; read data is taken at the ack edge only.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++)
      @(posedge clk_i);
    if (n == 50)
    begin
      err_total++;
      complete_run();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  // Offer one move and count clock states from acceptance to the done pulse.
  task automatic run(input step_s t, output int states);
    int n;
    @(posedge clk_i);
    wait_q      <= t.w;
    ins_size_i  <= t.sz;
    ins_mode_i  <= t.md;
    ins_store_i <= t.st;
    ins_dst_i   <= t.d;
    ins_src_i   <= t.s;
    ins_areg_i  <= t.a;
    ins_ext_i   <= t.x;
    ins_valid_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ins_ready_o !== 1'b1 && n < 50);
    ins_valid_i <= 1'b0;
    states = 1;
    do
    begin
      @(posedge clk_i);
      states++;
    end
    while (done_o !== 1'b1 && states < 200);
    if (n == 50 || states == 200)
    begin
      err_total++;
      complete_run();
    end
  endtask

  // Watchdog so a stuck handshake still reaches the verdict.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    int s;
    u_mem_model.mem[8'h10] = 8'h00;
    u_mem_model.mem[8'h11] = 8'h81;
    u_mem_model.mem[8'h12] = 8'h23;
    u_mem_model.mem[8'h80] = 8'h12;
    u_mem_model.mem[8'h81] = 8'h34;
    u_mem_model.mem[8'h51] = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_FLAGS, 32'h0);
    check("flags after reset", {24'h0, FLAGS_RESET}, rd);
    wb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl after reset", 32'h1, rd);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped read", 32'h0, rd);
    wb(1'b1, ADDR_FLAGS, 32'ha3);
    $display("test reset done");
    foreach (tbl[i])
    begin
      run(tbl[i], s);
      if (tbl[i].n != 5'h0)
        check("states", 32'(tbl[i].n), 32'(s));
      wb(1'b0, ADDR_FLAGS, 32'h0);
      check("flags", {24'h0, tbl[i].f}, rd);
      wb(1'b0, ADDR_GPR_BASE + {tbl[i].r, 2'b00}, 32'h0);
      check("register", tbl[i].rv, rd);
    end
    wb(1'b0, ADDR_COUNT, 32'h0);
    check("move count", 32'h12, rd);
    wb(1'b0, ADDR_STATUS, 32'h0);
    check("busy status", 32'h0, rd);
    $display("test moves done");
    check("stored byte", 32'h5a, {24'h0, u_mem_model.mem[8'h12]});
    check("stored word", 32'h5a80, {16'h0, u_mem_model.mem[8'h40], u_mem_model.mem[8'h41]});
    wb(1'b1, ADDR_GPR_BASE + 8'h08, 32'hffffffff);
    wb(1'b0, ADDR_GPR_BASE + 8'h08, 32'h0);
    check("read-only register", 32'h8000, rd);
    wb(1'b1, ADDR_CTRL, 32'h0);
    check("ready while disabled", 32'h0, {31'h0, ins_ready_o});
    wb(1'b1, ADDR_CTRL, 32'h1);
    $display("test bus done");
    complete_run();
  end
endmodule
